// ---- logic/fdr_map.vh ----
// register map, field positions, reset values and timing constants of the damper register bank
//
// Operation
// [R1] one flat table; register number equals zero-based address plus one
// [R2] no data-type split; every entry reachable by holding-register read and write
// [R3] function codes 3 and 6 standard; 2, 4 and 16 accepted too
// [R4] discrete-input read maps status word bits to address 104*16 plus bit
// [R5] writable values below address 100 are volatile; master should refresh them
// [R6] writable values above address 100 are kept across power loss
// [R7] override: 0 none, 1 open, 2 close; starts 0; writing 0 refused
// [R8] override 0 keeps damper in closed safety position
// [R9] command 2 starts test run, 4 resets faults; returns to 0 itself
// [R10] position reads 0 closed, 5000 intermediate, 10000 open
// [R11] collective fault reads 1 when any status bit 0..7 set
// [R12] serial parts one, two, four read-only at addresses 100, 101, 102
// [R13] firmware version at 103 as decimal, last two digits minor
// [R14] status low byte: bits 1,2,4,6,7 fault flags
// [R15] status high byte: bit 8 activity, 10 watchdog tripped, 11 local override
// [R16] fault reset clears latched faults except safety fault bit 4
// [R17] monitoring on and override not rewritten in 300 s: close, flag bit 10
// [R18] bus fail position 0 disables monitoring; 1 rapid close, factory default
// [R19] unassigned addresses read zero, writes ignored without exception
// [R20] writes to read-only registers leave them unchanged
`ifndef FDR_MAP_VH
`define FDR_MAP_VH

// ****************************************************************
// protocol addresses
// ****************************************************************
`define FDR_ADR_OVERRIDE 16'h0001
`define FDR_ADR_COMMAND 16'h0002
`define FDR_ADR_DRIVE_KIND 16'h0003
`define FDR_ADR_POSITION 16'h0004
`define FDR_ADR_FAULT 16'h0008
`define FDR_ADR_SERIAL1 16'h0064
`define FDR_ADR_SERIAL2 16'h0065
`define FDR_ADR_SERIAL4 16'h0066
`define FDR_ADR_FIRMWARE 16'h0067
`define FDR_ADR_STATUS 16'h0068
`define FDR_ADR_WD_ACTION 16'h006C
`define FDR_ADR_PERSIST_MIN 16'h0064
`define FDR_BIT_PER_REG 16'h0010

// ****************************************************************
// function codes
// ****************************************************************
`define FDR_FC_READ_BITS 8'h02
`define FDR_FC_READ_HOLD 8'h03
`define FDR_FC_READ_INPUT 8'h04
`define FDR_FC_WRITE_ONE 8'h06
`define FDR_FC_WRITE_MANY 8'h10

// ****************************************************************
// values and fields
// ****************************************************************
`define FDR_OVR_NONE 16'h0000
`define FDR_OVR_OPEN 16'h0001
`define FDR_OVR_CLOSE 16'h0002
`define FDR_CMD_NONE 16'h0000
`define FDR_CMD_TEST 16'h0002
`define FDR_CMD_RESET 16'h0004
`define FDR_POS_CLOSED 16'h0000
`define FDR_POS_MID 16'h1388
`define FDR_POS_OPEN 16'h2710
`define FDR_DRIVE_KIND_VAL 16'h0003
`define FDR_WD_OFF 16'h0000
`define FDR_WD_CLOSE 16'h0001
`define FDR_WD_RESET 16'h0001
`define FDR_ST_TRAVEL 1
`define FDR_ST_OVERLOAD 2
`define FDR_ST_SAFETY 4
`define FDR_ST_DUCT_TEMP 6
`define FDR_ST_SMOKE 7
`define FDR_ST_ACTIVITY 8
`define FDR_ST_WATCHDOG 10
`define FDR_ST_LOCAL 11
`define FDR_FAULT_MASK 16'h00D6
`define FDR_CLEARABLE_MASK 16'h00C6

// ****************************************************************
// timing
// ****************************************************************
`define FDR_CLK_HZ 250000000
`define FDR_WD_TIME_S 300
`define FDR_WD_CYCLES (64'd300 * 64'd250000000)

`endif

// ---- logic/fdr_nv_store.v ----
// small persistent word store for the non-volatile configuration registers
`timescale 1ns/1ps
module fdr_nv_store #(
  parameter AW = 2,
  parameter DW = 16,
  parameter [15:0] INIT = 16'h0001
) (
  input wire core_clk,
  input wire clk_en,
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [DW-1:0] wr_data,
  input wire [AW-1:0] rd_addr,
  output reg [DW-1:0] rd_data
);
  reg [DW-1:0] mem [0:(1<<AW)-1];
  integer i;

  // contents survive the core reset; only power-on initial state is set
  initial
  begin
    for (i = 0; i < (1<<AW); i = i + 1)
      mem[i] = INIT[DW-1:0];
  end

  always @(posedge core_clk)
  begin
    if (clk_en)
    begin
      if (wr_en)
        mem[wr_addr] <= wr_data;
      rd_data <= mem[rd_addr];
    end
  end
endmodule

// ---- logic/fdr_regs.v ----
// register bank and control logic of the fire damper bus unit
`timescale 1ns/1ps
`include "fdr_map.vh"
module fdr_regs #(
  parameter [63:0] WD_CYCLES = `FDR_WD_CYCLES,
  parameter [15:0] SERIAL1 = 16'h0001,
  parameter [15:0] SERIAL2 = 16'h0002,
  parameter [15:0] SERIAL4 = 16'h0004,
  parameter [15:0] FW_VERSION = 16'h0065
) (
  input wire core_clk,
  input wire arst_n,
  input wire clk_en,
  input wire req_valid,
  input wire [7:0] req_func,
  input wire [15:0] req_addr,
  input wire [15:0] req_wdata,
  input wire sw_closed,
  input wire sw_mid,
  input wire sw_open,
  input wire ev_travel,
  input wire ev_overload,
  input wire ev_safety,
  input wire ev_duct_temp,
  input wire ev_smoke,
  input wire busy,
  input wire local_override,
  output reg rsp_valid,
  output reg [15:0] rsp_data,
  output reg rsp_error,
  output reg drive_open,
  output reg rapid_close,
  output reg test_run_start,
  output reg fault_reset_pulse
);
  // ****************************************************************
  // state
  // ****************************************************************
  localparam ST_IDLE = 3'b001;
  localparam ST_READ = 3'b010;
  localparam ST_ANSW = 3'b100;

  reg [2:0] state;
  reg [15:0] override_setpoint;
  reg [15:0] service_command;
  reg [15:0] fault_latch;
  reg wd_tripped;
  reg [63:0] wd_count;
  reg [7:0] held_func;
  reg [15:0] held_addr;
  wire [15:0] watchdog_action;
  wire [15:0] fault_service_status;
  wire collective_fault;
  wire [15:0] relative_position;
  wire is_write;
  wire is_read;
  wire is_bit;
  wire nv_wr;
  wire wd_enabled;
  reg [15:0] reg_word;
  reg [15:0] next_rsp;

  // collapse any supported read/write code onto the one flat table
  function func_is_write;
    input [7:0] f;
    begin
      func_is_write = (f == `FDR_FC_WRITE_ONE) || (f == `FDR_FC_WRITE_MANY); // [R3] [R2]
    end
  endfunction

  function func_is_read;
    input [7:0] f;
    begin
      func_is_read = (f == `FDR_FC_READ_HOLD) || (f == `FDR_FC_READ_INPUT); // [R3] [R2]
    end
  endfunction

  // only open and close are accepted into the override setpoint
  function override_ok;
    input [15:0] a;
    input [15:0] d;
    begin
      override_ok = (a == `FDR_ADR_OVERRIDE)
        && ((d == `FDR_OVR_OPEN) || (d == `FDR_OVR_CLOSE)); // [R7]
    end
  endfunction

  assign is_write = func_is_write(req_func);
  assign is_read = func_is_read(req_func) || (req_func == `FDR_FC_READ_BITS);
  assign is_bit = (held_func == `FDR_FC_READ_BITS);

  // ****************************************************************
  // persistent configuration
  // ****************************************************************
  assign nv_wr = clk_en && state[0] && req_valid && is_write
    && (req_addr == `FDR_ADR_WD_ACTION)
    && ((req_wdata == `FDR_WD_OFF) || (req_wdata == `FDR_WD_CLOSE)); // [R6] [R18]

  fdr_nv_store #(
    .AW(2),
    .DW(16),
    .INIT(`FDR_WD_RESET)
  ) u_nv (
    .core_clk(core_clk),
    .clk_en(clk_en),
    .wr_en(nv_wr),
    .wr_addr(2'b00),
    .wr_data(req_wdata),
    .rd_addr(2'b00),
    .rd_data(watchdog_action)
  );

  assign wd_enabled = (watchdog_action != `FDR_WD_OFF); // [R18]

  // ****************************************************************
  // status word and derived values
  // ****************************************************************
  assign fault_service_status = {4'h0, local_override, wd_tripped, 1'b0, busy,
    fault_latch[7:0]}; // [R14] [R15]
  assign collective_fault = |fault_service_status[7:0]; // [R11]
  assign relative_position = sw_open ? `FDR_POS_OPEN :
    (sw_mid ? `FDR_POS_MID : `FDR_POS_CLOSED); // [R10]

  always @*
  begin
    case (held_addr)
      `FDR_ADR_OVERRIDE: reg_word = override_setpoint;
      `FDR_ADR_COMMAND: reg_word = service_command;
      `FDR_ADR_DRIVE_KIND: reg_word = `FDR_DRIVE_KIND_VAL;
      `FDR_ADR_POSITION: reg_word = relative_position;
      `FDR_ADR_FAULT: reg_word = {15'h0000, collective_fault}; // [R11]
      `FDR_ADR_SERIAL1: reg_word = SERIAL1; // [R12]
      `FDR_ADR_SERIAL2: reg_word = SERIAL2; // [R12]
      `FDR_ADR_SERIAL4: reg_word = SERIAL4; // [R12]
      `FDR_ADR_FIRMWARE: reg_word = FW_VERSION; // [R13]
      `FDR_ADR_STATUS: reg_word = fault_service_status;
      `FDR_ADR_WD_ACTION: reg_word = watchdog_action;
      default: reg_word = 16'h0000; // [R19]
    endcase
  end

  // bit reads address status bit n at 104*16+n; anything else reads zero
  always @*
  begin
    next_rsp = reg_word;
    if (is_bit)
    begin
      if ({4'h0, held_addr[15:4]} == `FDR_ADR_STATUS) // [R4]
        next_rsp = {15'h0000, fault_service_status[held_addr[3:0]]}; // [R4]
      else
        next_rsp = 16'h0000;
    end
  end

  // ****************************************************************
  // request handling
  // ****************************************************************
  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state <= ST_IDLE;
      held_func <= 8'h00;
      held_addr <= 16'h0000;
      rsp_valid <= 1'b0;
      rsp_data <= 16'h0000;
      rsp_error <= 1'b0;
      override_setpoint <= `FDR_OVR_NONE; // [R7] [R5]
      service_command <= `FDR_CMD_NONE;
    end
    else if (clk_en)
    begin
      rsp_valid <= 1'b0;
      rsp_error <= 1'b0;
      // command register clears itself one cycle after being taken
      service_command <= `FDR_CMD_NONE; // [R9]
      case (state)
        ST_IDLE:
        begin
          if (req_valid)
          begin
            held_func <= req_func;
            held_addr <= req_addr;
            if (is_write)
            begin
              // writes are acknowledged even to read-only or empty addresses
              if (override_ok(req_addr, req_wdata))
                override_setpoint <= req_wdata; // [R7]
              if (req_addr == `FDR_ADR_COMMAND
                && ((req_wdata == `FDR_CMD_TEST) || (req_wdata == `FDR_CMD_RESET)))
                service_command <= req_wdata; // [R9]
              rsp_valid <= 1'b1; // [R19] [R20]
              rsp_data <= req_wdata;
            end
            else if (is_read)
              state <= ST_READ;
            else
            begin
              rsp_valid <= 1'b1;
              rsp_error <= 1'b1;
            end
          end
        end
        ST_READ:
          state <= ST_ANSW;
        ST_ANSW:
        begin
          rsp_valid <= 1'b1;
          rsp_data <= next_rsp;
          state <= ST_IDLE;
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // faults, watchdog and drive
  // ****************************************************************
  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      fault_latch <= 16'h0000;
      wd_tripped <= 1'b0;
      wd_count <= 64'h0000000000000000;
      drive_open <= 1'b0;
      rapid_close <= 1'b0;
      test_run_start <= 1'b0;
      fault_reset_pulse <= 1'b0;
    end
    else if (clk_en)
    begin
      test_run_start <= (service_command == `FDR_CMD_TEST); // [R9]
      fault_reset_pulse <= (service_command == `FDR_CMD_RESET); // [R9]
      // new events win over a simultaneous reset; bit 4 is cleared only by arst_n
      fault_latch <= (service_command == `FDR_CMD_RESET ?
        (fault_latch & ~`FDR_CLEARABLE_MASK) : fault_latch) // [R16]
        | {8'h00, ev_smoke, ev_duct_temp, 1'b0, ev_safety, 1'b0, ev_overload,
          ev_travel, 1'b0}; // [R14]
      if (state[0] && req_valid && is_write && override_ok(req_addr, req_wdata))
      begin
        wd_count <= 64'h0000000000000000; // [R17]
        wd_tripped <= 1'b0;
      end
      else if (!wd_enabled)
      begin
        wd_count <= 64'h0000000000000000; // [R18]
        wd_tripped <= 1'b0;
      end
      else if (wd_count >= WD_CYCLES - 64'd1)
        wd_tripped <= 1'b1; // [R17]
      else
        wd_count <= wd_count + 64'd1;
      // only an explicit open without trip moves the damper off safety
      drive_open <= (override_setpoint == `FDR_OVR_OPEN) && !wd_tripped; // [R8] [R17]
      rapid_close <= wd_tripped && wd_enabled; // [R17] [R18]
    end
  end
endmodule

// ---- tb/fdr_master.sv ----
// fieldbus master model issuing one register request at a time
`timescale 1ns/1ps
module fdr_master (
  input wire core_clk,
  output reg req_valid,
  output reg [7:0] req_func,
  output reg [15:0] req_addr,
  output reg [15:0] req_wdata,
  input wire rsp_valid,
  input wire [15:0] rsp_data,
  input wire rsp_error
);
  // ****************************************
  // request driver
  // ****************************************
  initial
  begin
    req_valid = 1'b0;
    req_func = 8'h00;
    req_addr = 16'h0000;
    req_wdata = 16'h0000;
  end
  // a missing answer returns unknowns so any compare fails
  task xfer(input [7:0] f, input [15:0] a, input [15:0] d, output [15:0] q, output e);
    int n;
    begin
      @(posedge core_clk);
      req_valid <= 1'b1;
      req_func <= f;
      req_addr <= a;
      req_wdata <= d;
      @(posedge core_clk);
      req_valid <= 1'b0;
      req_func <= ~f;
      req_addr <= ~a;
      req_wdata <= ~d;
      n = 0;
      #1;
      while (rsp_valid !== 1'b1 && n < 8)
      begin
        @(posedge core_clk);
        #1;
        n = n + 1;
      end
      q = (n < 8) ? rsp_data : 16'hXXXX;
      e = (n < 8) ? rsp_error : 1'bX;
    end
  endtask
endmodule

// ---- tb/fdr_regs_assertions.sv ----
// timing checks on the damper register bank ports
`timescale 1ns/1ps
module fdr_regs_chk #(
  parameter [63:0] WD_CYCLES = 64'd20
) (
  input wire core_clk,
  input wire arst_n,
  input wire clk_en,
  input wire req_valid,
  input wire [7:0] req_func,
  input wire [15:0] req_addr,
  input wire [15:0] req_wdata,
  input wire rsp_valid,
  input wire rsp_error,
  input wire drive_open,
  input wire rapid_close,
  input wire test_run_start,
  input wire fault_reset_pulse
);
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  wire req = req_valid && clk_en;
  wire wr1 = req && (req_func == 8'h06 || req_func == 8'h10);
  wire ovr = wr1 && req_addr == 16'h0001 && (req_wdata == 16'h0001 || req_wdata == 16'h0002);
  wire good_fc = req_func inside {8'h02, 8'h03, 8'h04, 8'h06, 8'h10};
  reg [15:0] quiet;
  // cycles since the last accepted override write
  always @(posedge core_clk or negedge arst_n)
    if (!arst_n)
      quiet <= 16'h0000;
    else if (ovr)
      quiet <= 16'h0000;
    else if (quiet != 16'hFFFF)
      quiet <= quiet + 16'h0001;
  sequence s_read_wait;
    !rsp_valid [*2] ##1 rsp_valid;
  endsequence
  sequence s_reset_pulse;
    fault_reset_pulse ##1 !fault_reset_pulse;
  endsequence
  sequence s_test_pulse;
    test_run_start ##1 !test_run_start;
  endsequence
  property p_write_ack;
    req && req_func == 8'h06 |=> rsp_valid && !rsp_error;
  endproperty
  property p_read_lat;
    req && req_func == 8'h03 |=> s_read_wait;
  endproperty
  property p_bad_func;
    req && !good_fc |-> ##[1:3] (rsp_valid && rsp_error);
  endproperty
  property p_open_cause;
    $rose(drive_open) |-> $past(ovr && req_wdata == 16'h0001, 2) || $past(rapid_close, 2);
  endproperty
  property p_close_excl;
    rapid_close |-> !drive_open;
  endproperty
  property p_reset_cmd;
    wr1 && req_addr == 16'h0002 && req_wdata == 16'h0004 |-> ##2 s_reset_pulse;
  endproperty
  property p_test_cmd;
    wr1 && req_addr == 16'h0002 && req_wdata == 16'h0002 |-> ##2 s_test_pulse;
  endproperty
  property p_wd_time;
    $rose(rapid_close) |-> quiet + 3 >= WD_CYCLES && quiet <= WD_CYCLES + 3;
  endproperty
  a_write_ack: assert property (p_write_ack) else $error("write not acknowledged");
  a_read_lat: assert property (p_read_lat) else $error("read answer late");
  a_bad_func: assert property (p_bad_func) else $error("bad code not flagged");
  a_open_cause: assert property (p_open_cause) else $error("opened without cause");
  a_close_excl: assert property (p_close_excl) else $error("open while tripped");
  a_reset_cmd: assert property (p_reset_cmd) else $error("no fault reset pulse");
  a_test_cmd: assert property (p_test_cmd) else $error("no test run pulse");
  a_wd_time: assert property (p_wd_time) else $error("watchdog trip time wrong");
endmodule
bind fdr_regs fdr_regs_chk #(.WD_CYCLES(WD_CYCLES)) u_chk (.core_clk(core_clk),
  .arst_n(arst_n), .clk_en(clk_en), .req_valid(req_valid), .req_func(req_func),
  .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
  .rsp_error(rsp_error), .drive_open(drive_open), .rapid_close(rapid_close),
  .test_run_start(test_run_start), .fault_reset_pulse(fault_reset_pulse));

// ---- tb/fdr_regs_bench.sv ----
// self-checking bench of the damper register bank
`timescale 1ns/1ps
module fdr_regs_bench;
  // ****************************************
  // setup
  // ****************************************
  localparam int WD = 200;
  localparam [15:0] S1 = 16'h1357; // arbitrary value
  localparam [15:0] S2 = 16'h2468; // arbitrary value
  localparam [15:0] S4 = 16'h0042; // arbitrary value
  localparam [15:0] FW = 16'h00CB;
  logic core_clk = 1'b0, arst_n = 1'b0, clk_en = 1'b1, busy = 1'b0, local_override = 1'b0;
  logic sw_closed = 1'b0, sw_mid = 1'b0, sw_open = 1'b0;
  logic ev_travel = 1'b0, ev_overload = 1'b0, ev_safety = 1'b0, ev_duct_temp = 1'b0;
  logic ev_smoke = 1'b0;
  wire req_valid, rsp_valid, rsp_error, drive_open, rapid_close, test_run_start, fault_reset_pulse;
  wire [7:0] req_func;
  wire [15:0] req_addr, req_wdata, rsp_data;
  int n_mismatch = 0, checks = 0, cyc = 0, n;
  logic [15:0] ra [0:11] = '{16'h0001, 16'h0002, 16'h0003, 16'h0004, 16'h0008, 16'h0064,
    16'h0065, 16'h0066, 16'h0067, 16'h0068, 16'h0000, 16'h0005};
  logic [15:0] re [0:11] = '{16'h0000, 16'h0000, 16'h0003, 16'h0000, 16'h0000, S1, S2, S4,
    FW, 16'h0000, 16'h0000, 16'h0000};
  logic [2:0] pin [0:3] = '{3'b001, 3'b010, 3'b100, 3'b110};
  logic [15:0] pex [0:3] = '{16'h0000, 16'h1388, 16'h2710, 16'h2710};
  fdr_master m (.core_clk(core_clk), .req_valid(req_valid), .req_func(req_func),
    .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .rsp_error(rsp_error));
  fdr_regs #(.WD_CYCLES(WD), .SERIAL1(S1), .SERIAL2(S2), .SERIAL4(S4), .FW_VERSION(FW)) dut (
    .core_clk(core_clk), .arst_n(arst_n), .clk_en(clk_en), .req_valid(req_valid),
    .req_func(req_func), .req_addr(req_addr), .req_wdata(req_wdata), .sw_closed(sw_closed),
    .sw_mid(sw_mid), .sw_open(sw_open), .ev_travel(ev_travel), .ev_overload(ev_overload),
    .ev_safety(ev_safety), .ev_duct_temp(ev_duct_temp), .ev_smoke(ev_smoke), .busy(busy),
    .local_override(local_override), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .rsp_error(rsp_error), .drive_open(drive_open), .rapid_close(rapid_close),
    .test_run_start(test_run_start), .fault_reset_pulse(fault_reset_pulse));
  initial
  begin
    forever #2 core_clk = ~core_clk;
  end
  // ****************************************
  // helpers and scenarios
  // ****************************************
  task print_verdict;
    if (n_mismatch == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_mismatch = n_mismatch + 1;
      print_verdict();
    end
  end
  task chk(input [15:0] got, input [15:0] exp);
    checks = checks + 1;
    if (got !== exp)
    begin
      n_mismatch = n_mismatch + 1;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task rd(input [15:0] a, input [15:0] x, input [7:0] f = 8'h03);
    logic [15:0] q;
    logic e;
    m.xfer(f, a, 16'h0000, q, e);
    chk(q, x);
  endtask
  task wr(input [15:0] a, input [15:0] d, input [7:0] f = 8'h06);
    logic [15:0] q;
    logic e;
    m.xfer(f, a, d, q, e);
    chk({15'h0000, e}, 16'h0000);
  endtask
  task t_table;
    rd(16'h006C, 16'h0001);
    wr(16'h006C, 16'h0000);
    for (int i = 0; i < 12; i++)
      rd(ra[i], re[i]);
    for (int i = 2; i < 12; i++)
    begin
      wr(ra[i], 16'hA5A5);
      rd(ra[i], re[i]);
    end
  endtask
  task t_override;
    logic [15:0] q;
    logic e;
    wr(16'h0001, 16'h0000);
    rd(16'h0001, 16'h0000);
    chk({15'h0000, drive_open}, 16'h0000);
    wr(16'h0001, 16'h0001, 8'h10);
    rd(16'h0001, 16'h0001, 8'h04);
    chk({15'h0000, drive_open}, 16'h0001);
    wr(16'h0001, 16'h0002);
    wr(16'h0001, 16'h0000);
    rd(16'h0001, 16'h0002);
    chk({15'h0000, drive_open}, 16'h0000);
    m.xfer(8'h05, 16'h0001, 16'h0001, q, e);
    chk({15'h0000, e}, 16'h0001);
    for (int i = 0; i < 4; i++)
    begin
      {sw_open, sw_mid, sw_closed} <= pin[i];
      rd(16'h0004, pex[i]);
    end
  endtask
  task t_watchdog;
    wr(16'h006C, 16'h0001);
    wr(16'h0001, 16'h0001);
    n = 0;
    while (rapid_close !== 1'b1 && n < WD + 50)
    begin
      @(posedge core_clk);
      #1;
      n = n + 1;
    end
    chk({15'h0000, rapid_close}, 16'h0001);
    chk({15'h0000, drive_open}, 16'h0000);
    rd(16'h0068, 16'h0400);
    wr(16'h006C, 16'h0000);
    repeat (WD + 20) @(posedge core_clk);
    chk({15'h0000, rapid_close}, 16'h0000);
    rd(16'h0068, 16'h0000);
  endtask
  task t_faults;
    @(posedge core_clk);
    {ev_travel, ev_overload, ev_safety, ev_duct_temp, ev_smoke} <= 5'h1F;
    busy <= 1'b1;
    local_override <= 1'b1;
    @(posedge core_clk);
    {ev_travel, ev_overload, ev_safety, ev_duct_temp, ev_smoke} <= 5'h00;
    rd(16'h0068, 16'h09D6);
    rd(16'h0008, 16'h0001);
    rd(16'h0686, 16'h0001, 8'h02);
    rd(16'h0683, 16'h0000, 8'h02);
    wr(16'h0002, 16'h0002);
    wr(16'h0002, 16'h0004);
    rd(16'h0002, 16'h0000);
    rd(16'h0068, 16'h0910);
    busy <= 1'b0;
    local_override <= 1'b0;
    rd(16'h0068, 16'h0010);
    rd(16'h0008, 16'h0001);
    rd(16'h0686, 16'h0000, 8'h02);
  endtask
  task t_power;
    wr(16'h0001, 16'h0001);
    @(posedge core_clk);
    arst_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    arst_n <= 1'b1;
    rd(16'h006C, 16'h0000);
    rd(16'h0001, 16'h0000);
    chk({15'h0000, drive_open}, 16'h0000);
  endtask
  initial
  begin
    repeat (20) @(posedge core_clk);
    arst_n <= 1'b1;
    t_table();
    t_override();
    t_watchdog();
    t_faults();
    t_power();
    print_verdict();
  end
endmodule
